// ---- include/smroe_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef SMROE_REGS_SVH
`define SMROE_REGS_SVH
// ==========================================================================
// Register indices and byte addresses
`define SMROE_IDX_MODE 4'h1
`define SMROE_IDX_SRST 4'h2
`define SMROE_IDX_OUTEN 4'h3
`define SMROE_IDX_CTRL 4'h4
`define SMROE_IDX_STAT 4'h5
`define SMROE_ADDR_MODE 6'h04
`define SMROE_ADDR_SRST 6'h08
`define SMROE_ADDR_OUTEN 6'h0c
`define SMROE_ADDR_CTRL 6'h10
`define SMROE_ADDR_STAT 6'h14
// ==========================================================================
// Field positions
`define SMROE_MODE_START 0
`define SMROE_MODE_PAT_LO 1
`define SMROE_MODE_PAT_HI 3
`define SMROE_MODE_HI 8
`define SMROE_SRST_PLL 0
`define SMROE_SRST_SW 1
`define SMROE_OUTEN_HI 8
`define SMROE_OUTEN_CK5 5
`define SMROE_OUTEN_FP0 6
`define SMROE_CTRL_BPE 0
// ==========================================================================
// Reset values
`define SMROE_MODE_RST 16'h0000
`define SMROE_SRST_RST 16'h0000
`define SMROE_OUTEN_RST 16'h0000
`define SMROE_CTRL_RST 16'h0000
// ==========================================================================
// Timing: a frame is 125 us; programming finishes within two frames.
`define SMROE_FRAME_NS 125000
`define SMROE_CLK_NS 20
`define SMROE_FRAMES 2
`define SMROE_PROG_CYC ((`SMROE_FRAME_NS * `SMROE_FRAMES) / `SMROE_CLK_NS)
`endif

// ---- include/smroe_pkg.sv ----
// Types shared by the register bank.
package smroe_pkg;
   typedef enum logic [1:0] {
      SMROE_IDLE = 2'b00,
      SMROE_PROG = 2'b01
   } smroe_prog_e;
   typedef logic [15:0] smroe_word_t;
endpackage

// ---- include/smroe_prog_if.sv ----
// Handshake between register bank and block programming sequencer.
`timescale 1ns/10ps
interface smroe_prog_if;
   logic start;
   logic abort;
   logic busy;
   logic done;
   modport bank (output start, output abort, input busy, input done);
   modport seq (input start, input abort, output busy, output done);
endinterface

// ---- hdl/smroe_prog_seq.sv ----
// Block programming sequencer: runs for two frames unless aborted.
`timescale 1ns/10ps
`include "smroe_regs.svh"
module smroe_prog_seq #(
   parameter int unsigned PROG_CYCLES = `SMROE_PROG_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Bank side.
   smroe_prog_if.seq prog
);
   typedef struct packed {
      smroe_pkg::smroe_prog_e st;
      logic [17:0] cnt;
      logic done;
   } smroe_seq_s;
   smroe_seq_s s_reg;
   smroe_seq_s s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.st)
         smroe_pkg::SMROE_IDLE: begin
            if (prog.start) begin
               s_next.st = smroe_pkg::SMROE_PROG;
               s_next.cnt = 18'h00000;
            end
         end
         smroe_pkg::SMROE_PROG: begin
            if (prog.abort) begin
               s_next.st = smroe_pkg::SMROE_IDLE;
            end else if (s_reg.cnt == 18'(PROG_CYCLES - 1)) begin
               s_next.st = smroe_pkg::SMROE_IDLE;
               s_next.done = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt + 18'h00001;
            end
         end
         default: s_next.st = smroe_pkg::SMROE_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prog.busy = (s_reg.st == smroe_pkg::SMROE_PROG);
   assign prog.done = s_reg.done;
endmodule

// ---- hdl/smroe_bank.sv ----
// AXI4-Lite register bank: mode, software reset and output enables.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "smroe_regs.svh"
module smroe_bank #(
   parameter int unsigned PROG_CYCLES = `SMROE_PROG_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // AXI4-Lite write address and data.
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Block controls.
   output logic switch_soft_reset,
   output logic pll_soft_reset,
   output logic [2:0] block_prog_pattern,
   output logic block_prog_busy,
   // Output enables, low while driving.
   output logic [2:0] offset_frame_pulse_oe_n,
   output logic out_clock5_oe_n
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic [5:0] awaddr;
      logic haveAw;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic haveW;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      smroe_pkg::smroe_word_t mode;
      smroe_pkg::smroe_word_t srst;
      smroe_pkg::smroe_word_t outen;
      smroe_pkg::smroe_word_t ctrl;
      logic start;
      logic abort;
      logic busy;
      logic [2:0] fpOeN;
      logic ck5OeN;
   } smroe_bank_s;
   smroe_bank_s s_reg;
   smroe_bank_s s_next;
   smroe_prog_if prog ();

   // Byte-lane merge; the upper two lanes are ignored for 16-bit registers.
   function automatic smroe_pkg::smroe_word_t merge(
      input smroe_pkg::smroe_word_t old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      smroe_pkg::smroe_word_t res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[15:8] = data[15:8];
      return res;
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      return a == `SMROE_ADDR_MODE || a == `SMROE_ADDR_SRST ||
         a == `SMROE_ADDR_OUTEN || a == `SMROE_ADDR_CTRL ||
         a == `SMROE_ADDR_STAT;
   endfunction

   // ========================================================================
   // Bus and register logic
   always_comb begin
      smroe_pkg::smroe_word_t nw;
      logic oldStart;
      logic oldBpe;
      nw = '0;
      oldStart = s_reg.mode[`SMROE_MODE_START];
      oldBpe = s_reg.ctrl[`SMROE_CTRL_BPE];
      s_next = s_reg;
      s_next.start = 1'b0;
      s_next.abort = 1'b0;
      s_next.busy = prog.busy;
      s_next.awready = 1'b0;
      s_next.wready = 1'b0;
      s_next.arready = 1'b0;
      if (s_axi_awvalid && !s_reg.haveAw && !s_reg.awready &&
            !s_reg.bvalid) begin
         s_next.awready = 1'b1;
         s_next.awaddr = s_axi_awaddr;
         s_next.haveAw = 1'b1;
      end
      if (s_axi_wvalid && !s_reg.haveW && !s_reg.wready &&
            !s_reg.bvalid) begin
         s_next.wready = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
         s_next.haveW = 1'b1;
      end
      // Completion has priority below a same-cycle software write.
      if (prog.done) begin
         s_next.mode[`SMROE_MODE_START] = 1'b0;
      end
      if (s_reg.haveAw && s_reg.haveW) begin
         s_next.haveAw = 1'b0;
         s_next.haveW = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = mapped(s_reg.awaddr) ? 2'b00 : 2'b10;
         unique case (s_reg.awaddr)
            `SMROE_ADDR_MODE: begin
               nw = merge(s_reg.mode, s_reg.wdata, s_reg.wstrb);
               nw[15:`SMROE_MODE_HI + 1] = '0;
               s_next.mode = nw;
               // Start and pattern land together in one write.
               if (!oldStart && nw[`SMROE_MODE_START]) begin
                  s_next.start = 1'b1;
               end
               if (oldStart && !nw[`SMROE_MODE_START]) begin
                  s_next.abort = 1'b1;
               end
            end
            `SMROE_ADDR_SRST: begin
               nw = merge(s_reg.srst, s_reg.wdata, s_reg.wstrb);
               s_next.srst = {14'h0000, nw[1:0]};
            end
            `SMROE_ADDR_OUTEN: begin
               nw = merge(s_reg.outen, s_reg.wdata, s_reg.wstrb);
               s_next.outen = {7'h00, nw[`SMROE_OUTEN_HI:0]};
            end
            `SMROE_ADDR_CTRL: begin
               nw = merge(s_reg.ctrl, s_reg.wdata, s_reg.wstrb);
               s_next.ctrl = {15'h0000, nw[`SMROE_CTRL_BPE]};
               if (oldStart && oldBpe && !nw[`SMROE_CTRL_BPE]) begin
                  s_next.abort = 1'b1;
                  s_next.mode[`SMROE_MODE_START] = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // Enables are inverted here so that the pins come straight from flops.
      s_next.fpOeN =
         ~s_next.outen[`SMROE_OUTEN_FP0 + 2:`SMROE_OUTEN_FP0];
      s_next.ck5OeN = ~s_next.outen[`SMROE_OUTEN_CK5];
      // Programming only proceeds while enable is high.
      if (s_next.start && !s_next.ctrl[`SMROE_CTRL_BPE]) begin
         s_next.start = 1'b0;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_reg.arready && !s_reg.rvalid) begin
         s_next.arready = 1'b1;
         s_next.rvalid = 1'b1;
         s_next.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         unique case (s_axi_araddr)
            `SMROE_ADDR_MODE: s_next.rdata = {16'h0000, s_reg.mode};
            `SMROE_ADDR_SRST: s_next.rdata = {16'h0000, s_reg.srst};
            `SMROE_ADDR_OUTEN: s_next.rdata = {16'h0000, s_reg.outen};
            `SMROE_ADDR_CTRL: s_next.rdata = {16'h0000, s_reg.ctrl};
            `SMROE_ADDR_STAT: s_next.rdata = {31'h00000000, prog.busy};
            default: s_next.rdata = 32'h00000000;
         endcase
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.mode <= `SMROE_MODE_RST;
         s_reg.srst <= `SMROE_SRST_RST;
         s_reg.outen <= `SMROE_OUTEN_RST;
         s_reg.ctrl <= `SMROE_CTRL_RST;
         // All enables reset clear, so every pin starts high impedance.
         s_reg.fpOeN <= '1;
         s_reg.ck5OeN <= 1'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ========================================================================
   // Sequencer
   assign prog.start = s_reg.start;
   assign prog.abort = s_reg.abort;

   smroe_prog_seq #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_seq (
      .clk(clk),
      .reset(reset),
      .prog(prog)
   );

   // ========================================================================
   // Outputs, all straight from the state register
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign switch_soft_reset = s_reg.srst[`SMROE_SRST_SW];
   assign pll_soft_reset = s_reg.srst[`SMROE_SRST_PLL];
   assign block_prog_pattern =
      s_reg.mode[`SMROE_MODE_PAT_HI:`SMROE_MODE_PAT_LO];
   assign block_prog_busy = s_reg.busy;
   assign offset_frame_pulse_oe_n = s_reg.fpOeN;
   assign out_clock5_oe_n = s_reg.ck5OeN;
endmodule

// ---- bench/smroe_bank_properties.sv ----
// Concurrent checks on the ports of the register bank.
`timescale 1ns/10ps
module smroe_bank_properties #(
   parameter int unsigned PROG_CYCLES = 16
) (
   // Clock and reset.
   input wire logic clk, reset,
   // Bus handshakes and answers.
   input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   // Block controls.
   input wire logic switch_soft_reset, pll_soft_reset, block_prog_busy,
   input wire logic [2:0] block_prog_pattern, offset_frame_pulse_oe_n,
   input wire logic out_clock5_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // The sequencer lags the bank by a cycle, so allow a little slack.
   localparam int BusyMax = PROG_CYCLES + 4;
   int busyCnt;
   always_ff @(posedge clk) begin
      if (reset || !block_prog_busy) begin
         busyCnt <= 0;
      end else begin
         busyCnt <= busyCnt + 1;
      end
   end
   // ==================================================================
   // Assertions
   reset_values_a: assert property ($past(reset) |->
      offset_frame_pulse_oe_n == 3'h7 && out_clock5_oe_n &&
      !switch_soft_reset && !pll_soft_reset && !block_prog_busy)
      else $error("outputs not idle after reset");
   write_resp_a: assert property (s_axi_awready && s_axi_wready |=>
      s_axi_bvalid) else $error("write response missing");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write response dropped");
   read_resp_a: assert property (s_axi_arvalid && !s_axi_arready &&
      !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
      else $error("read answer missing");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   busy_bound_a: assert property (busyCnt <= BusyMax)
      else $error("programming ran too long");
   busy_cause_a: assert property ($rose(block_prog_busy) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) ||
      $past(s_axi_bvalid, 3)) else $error("programming began unasked");
   ctrl_cause_a: assert property ($changed({switch_soft_reset,
      pll_soft_reset, block_prog_pattern, offset_frame_pulse_oe_n,
      out_clock5_oe_n}) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("control output moved without a write");
   cover property ($fell(block_prog_busy));
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h0);
endmodule
bind smroe_bank smroe_bank_properties #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.*);

// ---- bench/smroe_bank_tb.sv ----
// Self-checking bench for the register bank against a behavioural model.
`timescale 1ns/10ps
module smroe_bank_tb;
   localparam int Prog = 16;
   logic clk = 1'h0, reset = 1'h1;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, switch_soft_reset, pll_soft_reset, block_prog_busy;
   logic out_clock5_oe_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] block_prog_pattern, offset_frame_pulse_oe_n;
   int miscompares = 0, nChecks = 0, cyc = 0, mReg[16], n;
   logic [15:0] seed = 16'h003b;
   bit slowW = 1'b0, slowR = 1'b0;
   smroe_bank #(.PROG_CYCLES(Prog)) dut_u (.*);
   always #10 clk = ~clk;
   // ==================================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic bit mapped(input logic [5:0] a);
      return a inside {6'h04, 6'h08, 6'h0c, 6'h10, 6'h14};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      nChecks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bit hs;
      slowW = !slowW;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      // Every other write raises bready late, so the response must wait.
      s_axi_bready <= !slowW;
      do begin
         @(posedge clk);
         hs = s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1 && !hs) s_axi_bready <= 1'h1;
      end while (!hs);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, mapped(a) ? 2'h0 : 2'h2);
      case (a)
         6'h04: mReg[1] = d & 32'h1ff;
         6'h08: mReg[2] = d & 32'h3;
         6'h0c: mReg[3] = d & 32'h1ff;
         6'h10: begin
            if (!d[0] && mReg[4][0]) mReg[1][0] = 1'h0;
            mReg[4] = d & 32'h1;
         end
         default: ;
      endcase
      @(posedge clk);
      chk({offset_frame_pulse_oe_n, out_clock5_oe_n, block_prog_pattern,
         switch_soft_reset, pll_soft_reset}, {~mReg[3][8:5],
         mReg[1][3:1], mReg[2][1:0]});
   endtask
   task automatic rd(input logic [5:0] a);
      bit hs;
      slowR = !slowR;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= !slowR;
      do begin
         @(posedge clk);
         hs = s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1 && !hs) s_axi_rready <= 1'h1;
      end while (!hs);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, mapped(a) ? mReg[a >> 2] : 0);
      chk(s_axi_rresp, mapped(a) ? 2'h0 : 2'h2);
      @(posedge clk);
   endtask
   task automatic waitBusy(input logic lvl, input int lim);
      n = 0;
      while (block_prog_busy !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(block_prog_busy, lvl);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   // ==================================================================
   // Main sequence
   initial begin
      foreach (mReg[i]) mReg[i] = 0;
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      for (int a = 4; a <= 20; a += 4) rd(6'(a));
      rd(6'h3c);
      wr(6'h3c, 32'hffff);
      $display("test reset and unmapped done");
      for (int i = 0; i < 4; i++) begin
         wr(6'h08, 32'(i));
         rd(6'h08);
      end
      repeat (4) begin
         seed = lfsr(seed);
         wr(6'h0c, {23'h0, seed[8:0]});
         rd(6'h0c);
      end
      wr(6'h0c, 32'h1ff);
      $display("test resets and enables done");
      wr(6'h10, 32'h1);
      seed = lfsr(seed);
      wr(6'h04, {28'h0, seed[2:0], 1'h1});
      waitBusy(1'h1, 5);
      waitBusy(1'h0, Prog + 8);
      chk(n, Prog);
      mReg[1][0] = 1'h0;
      rd(6'h04);
      rd(6'h14);
      wr(6'h04, {28'h0, seed[2:0], 1'h1});
      waitBusy(1'h1, 5);
      mReg[5] = 1;
      rd(6'h14);
      mReg[5] = 0;
      wr(6'h04, {28'h0, seed[2:0], 1'h0});
      waitBusy(1'h0, 3);
      rd(6'h14);
      wr(6'h04, 32'h5);
      waitBusy(1'h1, 5);
      wr(6'h10, 32'h0);
      waitBusy(1'h0, 3);
      rd(6'h04);
      wr(6'h04, 32'h0);
      wr(6'h04, 32'h7);
      repeat (6) @(posedge clk);
      chk(block_prog_busy, 1'h0);
      rd(6'h04);
      $display("test block programming done");
      finish_test();
   end
endmodule
